// ---- logic/uswc_pkg.sv ----
package uswc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0; // Control register
  localparam logic [3:0] STAT_OFS = 4'h4; // Flags and counter
  localparam logic [3:0] DATA_OFS = 4'h8; // Shift register
  localparam logic [3:0] PORT_OFS = 4'hC; // Port and direction bits
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int WM_LSB = 4;   // Wire mode select [5:4]
  localparam int CS_LSB = 2;   // Clock source select [3:2]
  localparam int STB_BIT = 1;  // Strobe select bit
  localparam int TGL_BIT = 0;  // Clock pin toggle
  // Status field positions
  localparam int SIF_BIT = 7;  // Start condition flag
  localparam int OIF_BIT = 6;  // Counter wrap flag
  // Port register field positions
  localparam int DO_PORT_BIT = 0;
  localparam int DI_PORT_BIT = 1;
  localparam int CK_PORT_BIT = 2;
  localparam int DO_DIR_BIT = 4;
  localparam int DI_DIR_BIT = 5;
  localparam int CK_DIR_BIT = 6;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hF;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} uswc_wm_t;
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] BRESP_OKAY = 2'h0;
  localparam logic [1:0] BRESP_SLVERR = 2'h2;
endpackage

// ---- logic/uswc_top.sv ----
`timescale 1ns/10ps
// How it works
// - Three-wire: serial output replaces data port bit
// - Three-wire input pin: pull-up follows port bit
// - Three-wire: data-in and clock pins stay normal
// - Two-wire: open-collector drivers enabled by direction
// - SDA low when output latch or port zero
// - SCL low on port zero or start hold
// - Start detected: hold SCL until flag cleared
// - Two-wire: SDA and SCL pull-ups off, inputs still work
// - Mode three: also hold SCL after wrap
// - External clock: output changes on opposite edge
// - Strobe or timer clock: output latch transparent
// - Source 00 strobe or none; 01 timer
// - External: bit0 picks edge; counter both edges
// - External: strobe bit selects toggle counter clock
// - Strobe shifts and counts once, reads zero
// - Strobe shifts in previously sampled input
// - Toggle inverts clock port bit, reads zero
// - External plus strobe bit: toggle counts
// - Wire mode 00: pins behave as ports
// - Wrap flag set on counter 15 to 0
// - Start flag clears only by writing one
module uswc_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic I_CLK_EN,
  input wire logic I_TIMER_OVF,
  input wire logic [3:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [3:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_DO_PIN_I,
  output logic O_DO_PIN_O,
  output logic O_DO_PIN_OE,
  output logic O_DO_PULLUP,
  input wire logic I_DI_PIN_I,
  output logic O_DI_PIN_O,
  output logic O_DI_PIN_OE,
  output logic O_DI_PULLUP,
  input wire logic I_CK_PIN_I,
  output logic O_CK_PIN_O,
  output logic O_CK_PIN_OE,
  output logic O_CK_PULLUP
);
  import uswc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_r; // First stage, read only by second stage
  logic [2:0] sync2_r; // Safe copies: {ck, di, do}
  logic ck_d_r; // Previous clock level for edge find
  logic di_d_r; // Previous data level for start detect
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      ck_d_r <= 1'b1;
      di_d_r <= 1'b1;
    end else if (I_CLK_EN) begin
      sync1_r <= {I_CK_PIN_I, I_DI_PIN_I, I_DO_PIN_I};
      sync2_r <= sync1_r;
      ck_d_r <= sync2_r[2];
      di_d_r <= sync2_r[1];
    end
  end
  logic ck_s; // Synchronised clock pin
  logic di_s; // Synchronised data pin
  assign ck_s = sync2_r[2];
  assign di_s = sync2_r[1];
  logic ck_rise;
  logic ck_fall;
  assign ck_rise = ck_s & ~ck_d_r;
  assign ck_fall = ~ck_s & ck_d_r;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt; // Control, toggle bit never stored, strobe bit kept only with external clock
  logic [7:0] port_r, port_nxt; // Port and direction bits
  logic [7:0] data_r, data_nxt; // Shift register
  logic [3:0] cnt_r, cnt_nxt; // 4-bit counter
  logic sif_r, sif_nxt; // Start condition flag
  logic oif_r, oif_nxt; // Counter wrap flag
  logic out_r, out_nxt; // Output latch
  logic di_smp_r, di_smp_nxt; // Input sampled one cycle back
  logic aw_r, aw_nxt; // Write address held
  logic w_r, w_nxt; // Write data held
  logic [3:0] awa_r, awa_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic wb0_r, wb0_nxt; // Low byte lane enabled
  logic bv_r, bv_nxt;
  logic [1:0] br_r, br_nxt;
  logic rv_r, rv_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic [1:0] rr_r, rr_nxt;
  logic [2:0] rdy_r, rdy_nxt; // Ready flags {aw, w, ar}, held in flops

  uswc_wm_t wm; // Wire mode in effect
  logic [1:0] cs; // Clock source in effect
  logic stb_sel; // Strobe select bit held
  assign wm = uswc_wm_t'(ctrl_r[WM_LSB +: 2]);
  assign cs = ctrl_r[CS_LSB +: 2];
  assign stb_sel = ctrl_r[STB_BIT];
  logic two_wire;
  assign two_wire = (wm == WM_TWO) || (wm == WM_TWO_HOLD);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic wr_go; // Both write halves present, response slot free
  logic [7:0] wval; // Written byte
  logic do_strobe; // Software shift strobe
  logic do_toggle; // Clock pin toggle strobe
  logic sh_clk; // Shift register clock
  logic cnt_clk; // Counter clock
  logic start_det; // Start seen on the lines
  logic flag_clr; // Status write that may clear flags
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    wb0_nxt = wb0_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    ctrl_nxt = ctrl_r;
    port_nxt = port_r;
    data_nxt = data_r;
    cnt_nxt = cnt_r;
    di_smp_nxt = di_s;
    // Channel capture; either order accepted
    if (I_AWVALID && O_AWREADY) begin
      aw_nxt = 1'b1;
      awa_nxt = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_nxt = 1'b1;
      wd_nxt = I_WDATA[7:0];
      wb0_nxt = I_WSTRB[0];
    end
    wr_go = aw_r && w_r && !bv_r;
    wval = wb0_r ? wd_r : 8'h00;
    do_strobe = 1'b0;
    do_toggle = 1'b0;
    if (bv_r && I_BREADY) begin
      bv_nxt = 1'b0;
    end
    if (wr_go) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = BRESP_OKAY;
      unique case (awa_r)
        CTRL_OFS: begin
          if (wb0_r) begin
            // Strobes act now, settings from next cycle on
            ctrl_nxt = {wval[7:2], 2'b00} | {6'h00, wval[STB_BIT] & wval[CS_LSB + 1], 1'b0};
            do_strobe = wval[STB_BIT] && (wval[CS_LSB +: 2] == CS_SOFT);
            do_toggle = wval[TGL_BIT];
          end
        end
        // Masked lane leaves the register as it was
        STAT_OFS: cnt_nxt = wb0_r ? wval[3:0] : cnt_r;
        DATA_OFS: data_nxt = wb0_r ? wval : data_r;
        PORT_OFS: port_nxt = wb0_r ? wval : port_r;
        default: begin
          br_nxt = BRESP_SLVERR;
        end
      endcase
    end
    // Toggle inverts the port bit whatever the direction
    if (do_toggle) begin
      port_nxt[CK_PORT_BIT] = ~port_r[CK_PORT_BIT];
    end
    // Shift clock; a write with the strobe bit and source 00 strobes at once
    unique case (cs)
      CS_SOFT: sh_clk = do_strobe;
      CS_TIMER: sh_clk = I_TIMER_OVF | do_strobe;
      2'h2: sh_clk = ck_rise | do_strobe;
      2'h3: sh_clk = ck_fall | do_strobe;
    endcase
    // Counter clock selection
    if (cs[1]) begin
      cnt_clk = (stb_sel ? do_toggle : (ck_rise | ck_fall)) | do_strobe;
    end else begin
      cnt_clk = sh_clk;
    end
    // Shift in the input sampled the cycle before
    if (sh_clk) begin
      data_nxt = {data_r[6:0], di_smp_r};
    end
    if (cnt_clk) begin
      cnt_nxt = cnt_r + 4'h1;
    end
    start_det = two_wire && ck_s && di_d_r && !di_s;
    // Flags: writing one clears, a new event wins
    flag_clr = wr_go && wb0_r && (awa_r == STAT_OFS);
    sif_nxt = start_det || (sif_r && !(flag_clr && wd_r[SIF_BIT]));
    oif_nxt = (cnt_clk && cnt_r == CNT_MAX) || (oif_r && !(flag_clr && wd_r[OIF_BIT]));
    // Output latch
    if (cs[1]) begin
      // Open in the half before the sampling edge, closed from that edge on
      out_nxt = (ck_s != cs[0]) ? out_r : data_nxt[7];
    end else begin
      out_nxt = data_nxt[7];
    end
    // Read channel
    if (rv_r && I_RREADY) begin
      rv_nxt = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      rv_nxt = 1'b1;
      rr_nxt = BRESP_OKAY;
      unique case (I_ARADDR)
        CTRL_OFS: rd_nxt = {ctrl_r[7:2], 2'b00};
        STAT_OFS: rd_nxt = {sif_r, oif_r, 2'b00, cnt_r};
        DATA_OFS: rd_nxt = data_r;
        PORT_OFS: rd_nxt = port_r;
        default: begin
          rd_nxt = 8'h00;
          rr_nxt = BRESP_SLVERR;
        end
      endcase
    end
    rdy_nxt = {!aw_nxt, !w_nxt, !rv_nxt}; // Empty slot means ready
  end

  // ----------------------------------------------------------------
  // Pin drive, computed one cycle ahead so outputs are flops
  // ----------------------------------------------------------------
  logic [8:0] pin_nxt; // {ck pu,oe,o, di pu,oe,o, do pu,oe,o}
  logic [8:0] pin_r;
  logic scl_hold; // Start or wrap hold of the clock line
  always_comb begin
    pin_nxt = {port_nxt[CK_PORT_BIT] & !port_nxt[CK_DIR_BIT], port_nxt[CK_DIR_BIT], port_nxt[CK_PORT_BIT],
               port_nxt[DI_PORT_BIT] & !port_nxt[DI_DIR_BIT], port_nxt[DI_DIR_BIT], port_nxt[DI_PORT_BIT],
               port_nxt[DO_PORT_BIT] & !port_nxt[DO_DIR_BIT], port_nxt[DO_DIR_BIT], port_nxt[DO_PORT_BIT]};
    scl_hold = sif_nxt || ((wm == WM_TWO_HOLD) && oif_nxt);
    unique case (wm)
      // Plain ports everywhere when off
      WM_OFF: pin_nxt[0] = port_nxt[DO_PORT_BIT];
      // Data output replaces port bit; direction and pull-up kept
      WM_THREE: pin_nxt[0] = out_nxt;
      WM_TWO, WM_TWO_HOLD: begin
        // Open collector: drive only a low, no pull-ups
        pin_nxt[5:3] = {1'b0, port_nxt[DI_DIR_BIT] && !(out_nxt && port_nxt[DI_PORT_BIT]), 1'b0};
        pin_nxt[8:6] = {1'b0, port_nxt[CK_DIR_BIT] && (!port_nxt[CK_PORT_BIT] || scl_hold), 1'b0};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_r <= CTRL_RST;
      port_r <= PORT_RST;
      data_r <= DATA_RST;
      cnt_r <= CNT_RST;
      sif_r <= 1'b0;
      oif_r <= 1'b0;
      out_r <= 1'b0;
      di_smp_r <= 1'b1;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 4'h0;
      wd_r <= 8'h00;
      wb0_r <= 1'b0;
      bv_r <= 1'b0;
      br_r <= BRESP_OKAY;
      rv_r <= 1'b0;
      rd_r <= 8'h00;
      rr_r <= BRESP_OKAY;
      pin_r <= 9'h000;
      rdy_r <= 3'h7;
    end else if (I_CLK_EN) begin
      ctrl_r <= ctrl_nxt;
      port_r <= port_nxt;
      data_r <= data_nxt;
      cnt_r <= cnt_nxt;
      sif_r <= sif_nxt;
      oif_r <= oif_nxt;
      out_r <= out_nxt;
      di_smp_r <= di_smp_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      wb0_r <= wb0_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
      pin_r <= pin_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready flags are flop states: accept only when the slot is empty
  assign O_AWREADY = rdy_r[2];
  assign O_WREADY = rdy_r[1];
  assign O_ARREADY = rdy_r[0];
  assign O_BVALID = bv_r;
  assign O_BRESP = br_r;
  assign O_RVALID = rv_r;
  assign O_RDATA = {24'h000000, rd_r};
  assign O_RRESP = rr_r;
  assign {O_CK_PULLUP, O_CK_PIN_OE, O_CK_PIN_O} = pin_r[8:6];
  assign {O_DI_PULLUP, O_DI_PIN_OE, O_DI_PIN_O} = pin_r[5:3];
  assign {O_DO_PULLUP, O_DO_PIN_OE, O_DO_PIN_O} = pin_r[2:0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_start_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && two_wire && sif_r && port_nxt[CK_DIR_BIT] && !(flag_clr && wd_r[SIF_BIT]))
    |=> (!I_CLK_EN || O_CK_PIN_OE))
    else $error("clock line released during start hold");
  a_wrap_flag: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && cnt_clk && cnt_r == 4'hF) |=> (oif_r && cnt_r == 4'h0))
    else $error("wrap flag not set on counter wrap");
  a_sif_sticky: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (sif_r && !(wr_go && awa_r == STAT_OFS && wb0_r && wd_r[SIF_BIT])) |=> sif_r)
    else $error("start flag cleared without write");
  a_toggle_flip: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && do_toggle && !(wr_go && awa_r == PORT_OFS)) |=> (port_r[CK_PORT_BIT] != $past(port_r[CK_PORT_BIT])))
    else $error("toggle did not invert clock port bit");
  a_strobe_shift: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && do_strobe) |=> (data_r[0] == $past(di_smp_r) && cnt_r == $past(cnt_r) + 4'h1))
    else $error("strobe shift or count wrong");
  a_no_pull_two: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && two_wire) |=> (!I_CLK_EN || (!O_CK_PULLUP && !O_DI_PULLUP && !O_CK_PIN_O && !O_DI_PIN_O)))
    else $error("two-wire pull-up or high drive");
  a_sda_low: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && two_wire && port_nxt[DI_DIR_BIT] && !port_nxt[DI_PORT_BIT]) |=> (!I_CLK_EN || O_DI_PIN_OE))
    else $error("data line not pulled low");
  a_three_out: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && wm == WM_THREE && $stable(wm)) |=> (!I_CLK_EN || O_DO_PIN_O == out_r))
    else $error("three-wire output not from latch");
  a_latch_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CLK_EN && cs[1] && (ck_s != cs[0])) |=> (out_r == $past(out_r)))
    else $error("output latch changed while closed");
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
  import uswc_pkg::*;
  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic tmr = 1'h0;
  logic cen = 1'h1; // Clock enable, dropped once to check freezing
  logic [3:0] wstrb = 4'hF; // Write strobes, lane 0 masked once
  logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rdat, rd_v;
  logic awr, wrdy, bv, arr, rv;
  logic [1:0] bresp, rresp, rsp_v;
  logic do_o, do_oe, do_pu, di_o, di_oe, di_pu, ck_o, ck_oe, ck_pu, do_pin, di_pin, ck_pin;
  int errors = 0;
  int check_count = 0;
  // Core clock, 5 ns period
  always #2.5 clk = ~clk;
  uswc_top u_dut (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CLK_EN(cen), .I_TIMER_OVF(tmr),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(wstrb), .I_WVALID(wv),
    .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rrdy),
    .I_DO_PIN_I(do_pin), .O_DO_PIN_O(do_o), .O_DO_PIN_OE(do_oe), .O_DO_PULLUP(do_pu),
    .I_DI_PIN_I(di_pin), .O_DI_PIN_O(di_o), .O_DI_PIN_OE(di_oe), .O_DI_PULLUP(di_pu),
    .I_CK_PIN_I(ck_pin), .O_CK_PIN_O(ck_o), .O_CK_PIN_OE(ck_oe), .O_CK_PULLUP(ck_pu)
  );
  uswc_peer u_peer (
    .i_do_o(do_o), .i_do_oe(do_oe), .i_do_pu(do_pu), .i_di_o(di_o), .i_di_oe(di_oe),
    .i_ck_o(ck_o), .i_ck_oe(ck_oe), .o_do_pin(do_pin), .o_di_pin(di_pin), .o_ck_pin(ck_pin)
  );
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_p;
    logic w_p;
    int n;
    aw_p = 1'h1;
    w_p = 1'h1;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (!aw_p && !w_p && bv === 1'h1) break;
      aw_p = aw_p && awr !== 1'h1;
      awv <= aw_p;
      w_p = w_p && wrdy !== 1'h1;
      wv <= w_p;
    end
    if (n >= 100) errors++;
    rsp_v = bresp;
    brdy <= 1'h0;
    // Let an edge pass so a following call never re-raises in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    logic ar_p;
    int n;
    ar_p = 1'h1;
    n = 0;
    ara <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (!ar_p && rv === 1'h1) break;
      ar_p = ar_p && arr !== 1'h1;
      arv <= ar_p;
    end
    if (n >= 100) errors++;
    rd_v = rdat;
    rsp_v = rresp;
    rrdy <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, rd_v);
  endtask
  // Covers pin synchronisers plus output register
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  // One-cycle timer overflow pulse
  task automatic tick;
    @(posedge clk) tmr <= 1'h1;
    @(posedge clk) tmr <= 1'h0;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize;
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rchk("ctrl", CTRL_OFS, {24'h0, CTRL_RST});
    rchk("data", DATA_OFS, {24'h0, DATA_RST});
    rchk("port", PORT_OFS, {24'h0, PORT_RST});
    rd(4'h2);
    chk("rresp", {30'h0, BRESP_SLVERR}, {30'h0, rsp_v});
    wr(4'h2, 32'hFF);
    chk("bresp", {30'h0, BRESP_SLVERR}, {30'h0, rsp_v});
    // Port pin first, then three-wire output override
    wr(PORT_OFS, 32'h10);
    wr(DATA_OFS, 32'hA5);
    settle;
    chk("do_o", 32'h0, do_o);
    wr(CTRL_OFS, 32'h10);
    settle;
    chk("do_o", 32'h1, do_o);
    chk("do_oe", 32'h1, do_oe);
    wr(CTRL_OFS, 32'h12);
    settle;
    chk("do_o", 32'h0, do_o);
    rchk("data", DATA_OFS, 32'h4B);
    rchk("stat", STAT_OFS, 32'h1);
    rchk("ctrl", CTRL_OFS, 32'h10);
    // Low input bit, then neither a clear strobe bit nor the timer clocks
    u_peer.drive_data(1'h0);
    settle;
    wr(CTRL_OFS, 32'h12);
    wr(CTRL_OFS, 32'h10);
    tick;
    rchk("data", DATA_OFS, 32'h96);
    rchk("stat", STAT_OFS, 32'h2);
    wr(CTRL_OFS, 32'h14);
    tick;
    rchk("stat", STAT_OFS, 32'h3);
    rchk("data", DATA_OFS, 32'h2C);
    // Counter wrap and flag clearing
    wr(STAT_OFS, 32'hF);
    tick;
    rchk("stat", STAT_OFS, 32'h40);
    wr(STAT_OFS, 32'h0);
    rchk("stat", STAT_OFS, 32'h40);
    wr(STAT_OFS, 32'h40);
    rchk("stat", STAT_OFS, 32'h0);
    // Enable low freezes timer clocking; a masked write changes nothing
    cen <= 1'h0;
    tick;
    cen <= 1'h1;
    rchk("stat", STAT_OFS, 32'h0);
    wstrb <= 4'hE;
    wr(CTRL_OFS, 32'h30);
    wstrb <= 4'hF;
    rchk("ctrl", CTRL_OFS, 32'h14);
    wr(PORT_OFS, 32'h01);
    settle;
    chk("do_pu", 32'h1, do_pu);
    chk("do_oe", 32'h0, do_oe);
    // Clock pin stays a port pin; toggle drives it
    wr(PORT_OFS, 32'h44);
    settle;
    chk("ck_o", 32'h1, ck_o);
    wr(CTRL_OFS, 32'h11);
    settle;
    chk("ck_o", 32'h0, ck_o);
    rchk("port", PORT_OFS, 32'h40);
    wr(PORT_OFS, 32'h00);
    wr(CTRL_OFS, 32'h11);
    settle;
    chk("ck_oe", 32'h0, ck_oe);
    rchk("port", PORT_OFS, 32'h04);
    rchk("ctrl", CTRL_OFS, 32'h10);
    // External clock: shift edge by select bit 0, counter on both edges
    u_peer.drive_data(1'h1);
    wr(CTRL_OFS, 32'h08);
    wr(DATA_OFS, 32'h0);
    wr(STAT_OFS, 32'h0);
    u_peer.clk_level(1'h0);
    settle;
    rchk("data", DATA_OFS, 32'h0);
    u_peer.clk_level(1'h1);
    settle;
    rchk("data", DATA_OFS, 32'h1);
    wr(CTRL_OFS, 32'h0C);
    u_peer.clk_level(1'h0);
    settle;
    rchk("data", DATA_OFS, 32'h3);
    u_peer.clk_level(1'h1);
    settle;
    rchk("stat", STAT_OFS, 32'h4);
    wr(CTRL_OFS, 32'h0A);
    u_peer.pulses(2);
    settle;
    rchk("data", DATA_OFS, 32'h0F);
    rchk("stat", STAT_OFS, 32'h4);
    wr(CTRL_OFS, 32'h0B);
    rchk("stat", STAT_OFS, 32'h5);
    rchk("ctrl", CTRL_OFS, 32'h08);
    // Two-wire open-collector drive, clock kept low to avoid false starts
    wr(CTRL_OFS, 32'h20);
    wr(STAT_OFS, 32'h0);
    wr(DATA_OFS, 32'h80);
    wr(PORT_OFS, 32'h66);
    settle;
    chk("di_oe", 32'h0, di_oe);
    chk("ck_oe", 32'h0, ck_oe);
    chk("di_pu", 32'h0, di_pu);
    chk("ck_pu", 32'h0, ck_pu);
    wr(PORT_OFS, 32'h62);
    settle;
    chk("ck_oe", 32'h1, ck_oe);
    wr(DATA_OFS, 32'h00);
    settle;
    chk("di_oe", 32'h1, di_oe);
    chk("di_o", 32'h0, di_o);
    wr(PORT_OFS, 32'h42);
    settle;
    chk("di_oe", 32'h0, di_oe);
    wr(DATA_OFS, 32'h80);
    wr(PORT_OFS, 32'h60);
    settle;
    chk("di_oe", 32'h1, di_oe);
    wr(PORT_OFS, 32'h66);
    u_peer.start_cond;
    settle;
    rchk("stat", STAT_OFS, 32'h80);
    chk("ck_oe", 32'h1, ck_oe);
    wr(STAT_OFS, 32'h0);
    settle;
    chk("ck_oe", 32'h1, ck_oe);
    wr(STAT_OFS, 32'h80);
    settle;
    chk("ck_oe", 32'h0, ck_oe);
    // Wrap holds the clock only in the second two-wire setting
    wr(DATA_OFS, 32'hFF);
    wr(STAT_OFS, 32'h0F);
    wr(CTRL_OFS, 32'h22);
    settle;
    chk("ck_oe", 32'h0, ck_oe);
    wr(STAT_OFS, 32'h4F);
    wr(CTRL_OFS, 32'h32);
    settle;
    chk("ck_oe", 32'h1, ck_oe);
    wr(STAT_OFS, 32'h40);
    settle;
    chk("ck_oe", 32'h0, ck_oe);
    summarize;
  end
endmodule

// ---- verification/uswc_peer.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far-side serial peer on the three pins
// ------------------------------------------------------------
module uswc_peer (
  input wire logic i_do_o,
  input wire logic i_do_oe,
  input wire logic i_do_pu,
  input wire logic i_di_o,
  input wire logic i_di_oe,
  input wire logic i_ck_o,
  input wire logic i_ck_oe,
  output logic o_do_pin,
  output logic o_di_pin,
  output logic o_ck_pin
);
  logic sda_drv; // Peer data drive, low pulls the line
  logic scl_drv; // Peer clock drive, stands high outside frames
  initial begin
    sda_drv = 1'h1;
    scl_drv = 1'h1;
  end
  // Wired-AND with bus pull-ups: any low driver wins
  assign o_di_pin = (i_di_oe ? i_di_o : 1'h1) & sda_drv;
  assign o_ck_pin = (i_ck_oe ? i_ck_o : 1'h1) & scl_drv;
  // Undriven without pull-up shows the inverse, so a stale level never passes
  assign o_do_pin = i_do_oe ? i_do_o : (i_do_pu ? 1'h1 : ~i_do_o);
  // Static data level for the next samples
  task automatic drive_data(input logic v);
    sda_drv = v;
  endtask
  // Single clock step, for edge polarity tests
  task automatic clk_level(input logic v);
    scl_drv = v;
  endtask
  // Clock pulses of 125 ns, low half then high half
  task automatic pulses(input int n);
    repeat (n) begin
      #62.5 scl_drv = 1'h0;
      #62.5 scl_drv = 1'h1;
    end
  endtask
  // Data falls with clock high, then clock dropped and let go
  task automatic start_cond;
    sda_drv = 1'h0;
    #125 scl_drv = 1'h0;
    #125 sda_drv = 1'h1;
    #62.5 scl_drv = 1'h1;
  endtask
endmodule
